// *** hw/rail_fault_defs.svh ***
// constants for the rail fault supervisor
`ifndef RAIL_FAULT_DEFS_SVH
`define RAIL_FAULT_DEFS_SVH
// ===========================================
// clock and timing
`define CLK_MHZ 200
`define FILT_NS 500
`define FILT_CYC ((`FILT_NS * `CLK_MHZ) / 1000)
`define XSHUT_NS 5000
`define XSHUT_CYC ((`XSHUT_NS * `CLK_MHZ) / 1000)
// ===========================================
// voltage levels, one lsb is 6.25 mV
`define TARGET_CODE0 10'h0F8
`define OFF_CODE 8'hF8
`define OV_MARGIN 12'h034
`define AOV_LEVEL 10'h128
`define DISCH_LEVEL 10'h050
`define CUR_FULL 8'hFF
// ===========================================
// reset values
`define GATE_RST 2'h0
`define SYNC_RST 3'h0
`endif

// *** hw/rail_fault_pkg.sv ***
// types shared by the rail fault supervisor
`default_nettype none
package rail_fault_pkg;
    typedef logic [9:0] volt_t;
    typedef logic [7:0] code_t;
    // gray along run -> wait -> shut
    typedef enum logic [1:0] {
        XS_RUN = 2'b00,
        XS_WAIT = 2'b01,
        XS_SHUT = 2'b11
    } xshut_state_t;
endpackage
`default_nettype wire

// *** hw/rail_monitor.sv ***
// per-rail voltage fault monitor with filters and fault latches
`timescale 1ns/10ps
`default_nettype none
`include "rail_fault_defs.svh"
module rail_monitor (
    input wire logic clk,
    input wire logic clear,
    input wire logic ce,
    input wire rail_fault_pkg::volt_t feedback,
    input wire rail_fault_pkg::volt_t droop,
    input wire rail_fault_pkg::code_t code,
    input wire rail_fault_pkg::code_t boot_code,
    output logic ov_trip,
    output logic uv_trip,
    output logic ov_flt,
    output logic uv_flt,
    output logic armed,
    output logic discharged,
    output logic code_off
);
    import rail_fault_pkg::*;

    volt_t target;
    volt_t boot_tgt;
    logic signed [11:0] fb_s;
    logic signed [11:0] ov_lim;
    logic signed [11:0] uv_lim;
    logic [2:0] cond;
    logic [2:0] hit;
    logic armed_reg, armed_next;
    logic ov_reg, ov_next, uv_reg, uv_next;
    logic dis_reg, dis_next;

    // =======================================
    // code decode and threshold compare
    always_comb begin
        code_off = (code >= `OFF_CODE); // off codes give no target
        target = code_off ? 10'h000 : `TARGET_CODE0 - {2'b00, code};
        boot_tgt = (boot_code >= `OFF_CODE) ? 10'h000 :
            `TARGET_CODE0 - {2'b00, boot_code};
        fb_s = $signed({2'b00, feedback});
        ov_lim = $signed({2'b00, target}) + $signed(`OV_MARGIN)
            - $signed({2'b00, droop});
        uv_lim = $signed({2'b00, target}) - $signed(`OV_MARGIN)
            - $signed({2'b00, droop});
        cond[0] = fb_s > ov_lim;
        cond[1] = feedback > `AOV_LEVEL;
        cond[2] = fb_s < uv_lim;
    end

    // =======================================
    // one persistence filter per comparator
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_filt
            logic [6:0] cnt_reg;
            logic [6:0] cnt_next;
            // count restarts whenever the condition drops out
            always_comb begin
                cnt_next = cnt_reg;
                // an off code has no target, so its limits mean nothing
                if (!armed_reg || code_off || !cond[i]) begin
                    cnt_next = 7'h00;
                end else if (cnt_reg != 7'(`FILT_CYC - 1)) begin
                    cnt_next = cnt_reg + 7'h01;
                end
            end
            assign hit[i] = armed_reg && !code_off && cond[i] &&
                (cnt_reg == 7'(`FILT_CYC - 1));
            always_ff @(posedge clk) begin
                if (clear) begin
                    cnt_reg <= 7'h00;
                end else if (ce) begin
                    cnt_reg <= cnt_next;
                end
            end
        end
    endgenerate

    // =======================================
    // arming and sticky fault bits
    always_comb begin
        // monitors wake once the rail has reached boot voltage
        armed_next = armed_reg ||
            (!code_off && feedback >= boot_tgt);
        ov_trip = (hit[0] || hit[1]) && !ov_reg;
        uv_trip = hit[2] && !uv_reg;
        ov_next = ov_reg || hit[0] || hit[1];
        uv_next = uv_reg || hit[2];
        // low side turns off below 0.5 v to avoid negative output
        dis_next = dis_reg ||
            (ov_reg && feedback < `DISCH_LEVEL);
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            armed_reg <= 1'b0;
            ov_reg <= 1'b0;
            uv_reg <= 1'b0;
            dis_reg <= 1'b0;
        end else if (ce) begin
            armed_reg <= armed_next;
            ov_reg <= ov_next;
            uv_reg <= uv_next;
            dis_reg <= dis_next;
        end
    end

    assign ov_flt = ov_reg;
    assign uv_flt = uv_reg;
    assign armed = armed_reg;
    assign discharged = dis_reg;

    // =======================================
    // checks
    sticky_fault_a: assert property (@(posedge clk) disable iff (clear)
        ov_reg |=> ov_reg)
        else $error("over-voltage latch released without clear");
    unarmed_quiet_a: assert property (@(posedge clk) disable iff (clear)
        !armed_reg |-> !ov_trip && !uv_trip && !ov_reg && !uv_reg)
        else $error("fault tripped before boot voltage reached");
    code_zero_a: assert property (@(posedge clk) disable iff (clear)
        code == 8'h00 |-> target == `TARGET_CODE0)
        else $error("code zero does not decode to 1.55 v");
    filter_hold_a: assert property (@(posedge clk) disable iff (clear)
        $rose(ov_reg) |-> $past(hit[0]) || $past(hit[1]))
        else $error("over-voltage set without a held condition");
endmodule
`default_nettype wire

// *** hw/rail_fault_supervisor.sv ***
// two-rail fault supervisor: protection, gate forcing and telemetry
//
// Behaviour
// - over, absolute over and under checks wait until rail reaches boot
// - over-voltage: feedback above target plus 325mV minus droop, filtered
// - over-voltage drops power good, upper gate low, lower gate high
// - during discharge lower gate turns off below about 0.5V
// - all faults latch; only supply detect or enable toggle clears
// - a rail voltage fault shuts the other rail about 5us later
// - absolute over-voltage: feedback above fixed 1.85V, filtered
// - absolute over-voltage responds like ordinary over-voltage
// - under-voltage: feedback below target minus 325mV minus droop
// - under-voltage drops power good and holds both gates low
// - over-temperature shuts both rails, all gates low, latched
// - over, absolute over and under comparators pass a fixed persistence filter
// - auxiliary rail gets identical checks from its own feedback
// - code zero is 1.55V, each step lowers target 6.25mV
// - feedback of both rails is reported as voltage telemetry
// - codes 1111_1000 and above request the rail off
// - current telemetry saturates at full scale code FFh
`timescale 1ns/10ps
`default_nettype none
`include "rail_fault_defs.svh"
module rail_fault_supervisor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic enable_pin,
    input wire logic supply_ok_pin,
    input wire logic over_temp_pin,
    input wire rail_fault_pkg::volt_t core_feedback,
    input wire rail_fault_pkg::volt_t aux_feedback,
    input wire rail_fault_pkg::volt_t core_droop,
    input wire rail_fault_pkg::volt_t aux_droop,
    input wire rail_fault_pkg::code_t core_voltage_code,
    input wire rail_fault_pkg::code_t aux_voltage_code,
    input wire rail_fault_pkg::code_t boot_code,
    input wire logic [1:0] pwm_upper,
    input wire logic [1:0] pwm_lower,
    input wire rail_fault_pkg::volt_t core_cur_sense,
    input wire rail_fault_pkg::volt_t aux_cur_sense,
    output logic [1:0] upper_gate_drive,
    output logic [1:0] lower_gate_drive,
    output logic power_good_out,
    output logic [9:0] core_volt_telem,
    output logic [9:0] aux_volt_telem,
    output logic [7:0] core_cur_telem,
    output logic [7:0] aux_cur_telem
);
    import rail_fault_pkg::*;

    // =======================================
    // pin synchronisers: enable, supply, temperature
    logic [2:0] sync1_reg, sync2_reg;
    logic en_ok;
    logic clear;
    logic hot_now;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= `SYNC_RST;
            sync2_reg <= `SYNC_RST;
        end else if (ce) begin
            sync1_reg <= {over_temp_pin, supply_ok_pin, enable_pin};
            sync2_reg <= sync1_reg;
        end
    end

    // a low phase of enable or supply detect is the only way out
    assign en_ok = sync2_reg[0] && sync2_reg[1];
    assign clear = rst || !en_ok;
    assign hot_now = sync2_reg[2];

    // =======================================
    // rail monitors, core is index 0, aux index 1
    volt_t fb_arr [2];
    volt_t droop_arr [2];
    code_t code_arr [2];
    logic [1:0] ov_trip, uv_trip, ov_flt, uv_flt;
    logic [1:0] armed, discharged, code_off;

    assign fb_arr[0] = core_feedback;
    assign fb_arr[1] = aux_feedback;
    assign droop_arr[0] = core_droop;
    assign droop_arr[1] = aux_droop;
    assign code_arr[0] = core_voltage_code;
    assign code_arr[1] = aux_voltage_code;

    genvar r;
    generate
        for (r = 0; r < 2; r = r + 1) begin : g_rail
            // aux rail runs the same monitor on its own feedback
            rail_monitor u_mon (
                .clk(clk),
                .clear(clear),
                .ce(ce),
                .feedback(fb_arr[r]),
                .droop(droop_arr[r]),
                .code(code_arr[r]),
                .boot_code(boot_code),
                .ov_trip(ov_trip[r]),
                .uv_trip(uv_trip[r]),
                .ov_flt(ov_flt[r]),
                .uv_flt(uv_flt[r]),
                .armed(armed[r]),
                .discharged(discharged[r]),
                .code_off(code_off[r])
            );
        end
    endgenerate

    // =======================================
    // thermal latch
    logic thermal_reg, thermal_next;

    always_comb begin
        thermal_next = thermal_reg || hot_now;
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            thermal_reg <= 1'b0;
        end else if (ce) begin
            thermal_reg <= thermal_next;
        end
    end

    // =======================================
    // cross-rail shutdown sequencer
    xshut_state_t xs_reg, xs_next;
    logic [9:0] xs_cnt_reg, xs_cnt_next;
    logic [1:0] first_reg, first_next;
    logic [1:0] vfault;

    assign vfault = ov_trip | uv_trip | ov_flt | uv_flt;

    // the rail that faulted first keeps its own response
    always_comb begin
        xs_next = xs_reg;
        xs_cnt_next = xs_cnt_reg;
        first_next = first_reg;
        case (xs_reg)
            XS_RUN: begin
                if (|vfault) begin
                    xs_next = XS_WAIT;
                    xs_cnt_next = 10'h000;
                    first_next = vfault;
                end
            end
            XS_WAIT: begin
                if (xs_cnt_reg == 10'(`XSHUT_CYC - 1)) begin
                    xs_next = XS_SHUT;
                end else begin
                    xs_cnt_next = xs_cnt_reg + 10'h001;
                end
            end
            XS_SHUT: begin
                xs_next = XS_SHUT;
            end
            default: begin
                xs_next = XS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            xs_reg <= XS_RUN;
            xs_cnt_reg <= 10'h000;
            first_reg <= 2'h0;
        end else if (ce) begin
            xs_reg <= xs_next;
            xs_cnt_reg <= xs_cnt_next;
            first_reg <= first_next;
        end
    end

    // =======================================
    // gate forcing and power good
    logic [1:0] up_next, lo_next;
    logic [1:0] up_reg, lo_reg;
    logic pg_reg, pg_next;
    logic all_off;

    // trips feed forward so outputs move on the same edge as the latch
    always_comb begin
        all_off = !en_ok || thermal_reg || hot_now;
        for (int k = 0; k < 2; k++) begin
            if (all_off) begin
                up_next[k] = 1'b0;
                lo_next[k] = 1'b0;
            end else if (ov_trip[k] || ov_flt[k]) begin
                up_next[k] = 1'b0;
                lo_next[k] = !discharged[k];
            end else if (uv_trip[k] || uv_flt[k] || code_off[k] ||
                (xs_reg == XS_SHUT && !first_reg[k])) begin
                up_next[k] = 1'b0;
                lo_next[k] = 1'b0;
            end else begin
                up_next[k] = pwm_upper[k];
                lo_next[k] = pwm_lower[k];
            end
        end
        // limitation: a rail parked off keeps power good low
        pg_next = !all_off && !(|vfault) && !(|code_off) &&
            (&armed);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            up_reg <= `GATE_RST;
            lo_reg <= `GATE_RST;
            pg_reg <= 1'b0;
        end else if (ce) begin
            up_reg <= up_next;
            lo_reg <= lo_next;
            pg_reg <= pg_next;
        end
    end

    assign upper_gate_drive = up_reg;
    assign lower_gate_drive = lo_reg;
    assign power_good_out = pg_reg;

    // =======================================
    // voltage and current telemetry
    logic [9:0] cvt_reg, avt_reg;
    logic [7:0] cct_reg, act_reg, cct_next, act_next;

    // converter range ends at full scale, never wraps
    always_comb begin
        cct_next = (core_cur_sense > 10'h0FF) ? `CUR_FULL :
            core_cur_sense[7:0];
        act_next = (aux_cur_sense > 10'h0FF) ? `CUR_FULL :
            aux_cur_sense[7:0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cvt_reg <= 10'h000;
            avt_reg <= 10'h000;
            cct_reg <= 8'h00;
            act_reg <= 8'h00;
        end else if (ce) begin
            cvt_reg <= core_feedback;
            avt_reg <= aux_feedback;
            cct_reg <= cct_next;
            act_reg <= act_next;
        end
    end

    assign core_volt_telem = cvt_reg;
    assign aux_volt_telem = avt_reg;
    assign core_cur_telem = cct_reg;
    assign aux_cur_telem = act_reg;

    // =======================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    pg_drop_a: assert property (
        ce && |(ov_trip | uv_trip) |=> !power_good_out)
        else $error("power good stayed high on a voltage trip");
    ov_gates_a: assert property (
        ce && ov_trip[0] && !all_off |=>
        !upper_gate_drive[0] && lower_gate_drive[0])
        else $error("over-voltage did not force discharge");
    uv_gates_a: assert property (
        ce && uv_flt[1] && !ov_flt[1] && !ov_trip[1] |=>
        !upper_gate_drive[1] && !lower_gate_drive[1])
        else $error("under-voltage left a gate on");
    disch_off_a: assert property (
        ce && discharged[0] |=> !lower_gate_drive[0])
        else $error("low side stayed on after discharge");
    thermal_off_a: assert property (
        ce && thermal_reg |=> upper_gate_drive == 2'h0 &&
        lower_gate_drive == 2'h0)
        else $error("gate active during thermal shutdown");
    thermal_hold_a: assert property (
        ce && thermal_reg && !clear |=> thermal_reg)
        else $error("thermal latch released");
    xs_wait_a: assert property (
        ce && !clear && xs_reg == XS_WAIT &&
        xs_cnt_reg == 10'(`XSHUT_CYC - 1) |=> xs_reg == XS_SHUT)
        else $error("cross shutdown missed its delay");
    xs_gate_a: assert property (
        ce && xs_reg == XS_SHUT && !first_reg[1] |=>
        !upper_gate_drive[1] && !lower_gate_drive[1])
        else $error("unaffected rail not shut down");
    off_code_a: assert property (
        ce && core_voltage_code >= `OFF_CODE |=> !upper_gate_drive[0])
        else $error("off code left rail switching");
    cur_sat_a: assert property (
        ce && core_cur_sense > 10'h0FF |=> core_cur_telem == `CUR_FULL)
        else $error("current telemetry not saturated");

    ov_seen_c: cover property (ce && ov_trip[0]);
    uv_seen_c: cover property (ce && uv_trip[1]);
    xs_shut_c: cover property (xs_reg == XS_SHUT);
    hot_seen_c: cover property ($rose(thermal_reg));
endmodule
`default_nettype wire

// *** verification/rail_power_plant.sv ***
// power stage and output filter model for both rails
`timescale 1ns/10ps
`default_nettype none
module rail_power_plant (
    input wire logic clk,
    input wire logic [1:0] upper_gate_drive,
    input wire logic [1:0] lower_gate_drive,
    input wire rail_fault_pkg::volt_t core_level,
    input wire rail_fault_pkg::volt_t aux_level,
    output var rail_fault_pkg::volt_t core_feedback,
    output var rail_fault_pkg::volt_t aux_feedback
);
    import rail_fault_pkg::*;
    localparam int DISCH_STEP = 4;
    // low side alone bleeds the output capacitor; a slow bleed keeps the
    // discharge visible for tens of cycles, otherwise the loop holds the
    // level asked for by the bench
    function automatic volt_t next_v(volt_t v, volt_t lvl, logic up,
            logic lo);
        if (lo && !up)
            return (v > DISCH_STEP) ? v - 10'(DISCH_STEP) : '0;
        return lvl;
    endfunction
    initial begin
        core_feedback = '0;
        aux_feedback = '0;
    end
    // sampled like an adc, updated just after the edge
    always @(posedge clk) begin
        core_feedback <= #1 next_v(core_feedback, core_level,
            upper_gate_drive[0], lower_gate_drive[0]);
        aux_feedback <= #1 next_v(aux_feedback, aux_level,
            upper_gate_drive[1], lower_gate_drive[1]);
    end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the rail fault supervisor
`timescale 1ns/10ps
`default_nettype none
`include "rail_fault_defs.svh"
`define CHECK_EQ(got, exp, msg) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("mismatch at %0t: %s", $time, msg); \
        end \
    end
module testbench;
    import rail_fault_pkg::*;
    // ==========================================
    // signals and derived limits
    localparam int FILT = `FILT_CYC;
    localparam int XSHUT = `XSHUT_CYC;
    localparam volt_t CORE_TGT = `TARGET_CODE0 - 10'h040;
    localparam volt_t AUX_TGT = `TARGET_CODE0;
    localparam volt_t CORE_DROOP = 10'h008;
    localparam volt_t MARGIN = volt_t'(`OV_MARGIN);
    localparam volt_t CORE_OV = CORE_TGT + MARGIN - CORE_DROOP;
    localparam volt_t CORE_UV = CORE_TGT - MARGIN - CORE_DROOP;
    logic clk, rst, ce, enable_pin, supply_ok_pin, over_temp_pin;
    volt_t core_feedback, aux_feedback, core_level, aux_level;
    volt_t core_cur_sense, aux_cur_sense;
    code_t core_voltage_code;
    logic [1:0] upper_gate_drive, lower_gate_drive;
    logic power_good_out;
    logic [9:0] core_volt_telem, aux_volt_telem;
    logic [7:0] core_cur_telem, aux_cur_telem;
    int err_count = 0;
    int num_checks = 0;

    rail_fault_supervisor dut (
        .clk(clk), .rst(rst), .ce(ce), .enable_pin(enable_pin),
        .supply_ok_pin(supply_ok_pin), .over_temp_pin(over_temp_pin),
        .core_feedback(core_feedback), .aux_feedback(aux_feedback),
        .core_droop(CORE_DROOP), .aux_droop(10'h000),
        .core_voltage_code(core_voltage_code),
        .aux_voltage_code(8'h00), .boot_code(8'h40),
        .pwm_upper(2'b11), .pwm_lower(2'b00),
        .core_cur_sense(core_cur_sense), .aux_cur_sense(aux_cur_sense),
        .upper_gate_drive(upper_gate_drive),
        .lower_gate_drive(lower_gate_drive),
        .power_good_out(power_good_out),
        .core_volt_telem(core_volt_telem), .aux_volt_telem(aux_volt_telem),
        .core_cur_telem(core_cur_telem), .aux_cur_telem(aux_cur_telem));

    rail_power_plant plant (
        .clk(clk), .upper_gate_drive(upper_gate_drive),
        .lower_gate_drive(lower_gate_drive), .core_level(core_level),
        .aux_level(aux_level), .core_feedback(core_feedback),
        .aux_feedback(aux_feedback));

    // ==========================================
    // shared tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // either pin toggle must clear; supply path and enable path both used
    task automatic clear_latch(input logic by_supply);
        core_level = CORE_TGT;
        aux_level = AUX_TGT;
        core_voltage_code = 8'h40;
        if (by_supply)
            supply_ok_pin = 1'b0;
        else
            enable_pin = 1'b0;
        step(5);
        supply_ok_pin = 1'b1;
        enable_pin = 1'b1;
        step(12);
        `CHECK_EQ(power_good_out, 1'b1, "pg after clear") // cleared
        `CHECK_EQ(upper_gate_drive, 2'b11, "gates after clear") // run
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_unarmed();
        step(2 * FILT);
        `CHECK_EQ(power_good_out, 1'b0, "pg before boot") // not armed
        core_level = CORE_TGT;
        aux_level = AUX_TGT;
        step(12);
        `CHECK_EQ(power_good_out, 1'b1, "pg after boot") // no uv latch
        `CHECK_EQ(upper_gate_drive, 2'b11, "upper normal") // no fault
        `CHECK_EQ(lower_gate_drive, 2'b00, "lower normal") // no fault
    endtask

    task automatic t_telemetry();
        core_cur_sense = 10'h3FF;
        aux_cur_sense = 10'h0AB;
        step(2);
        `CHECK_EQ(core_volt_telem, CORE_TGT, "core telem") // feedback
        `CHECK_EQ(aux_volt_telem, AUX_TGT, "aux telem") // feedback
        `CHECK_EQ(core_cur_telem, `CUR_FULL, "cur sat") // clipped
        `CHECK_EQ(aux_cur_telem, 8'hAB, "cur in range") // passes
    endtask

    task automatic t_ov_core();
        core_level = CORE_OV + 10'h001;
        step(FILT - 1);
        core_level = CORE_TGT;
        step(10);
        `CHECK_EQ(power_good_out, 1'b1, "short ov") // filtered out
        core_level = CORE_OV;
        step(150);
        `CHECK_EQ(power_good_out, 1'b1, "ov at limit") // threshold
        core_level = CORE_OV + 10'h001;
        step(FILT - 2);
        `CHECK_EQ(power_good_out, 1'b1, "ov early") // delay holds
        step(6);
        `CHECK_EQ(power_good_out, 1'b0, "ov pg") // pg drops
        `CHECK_EQ(upper_gate_drive, 2'b10, "ov upper") // upper off
        `CHECK_EQ(lower_gate_drive, 2'b01, "ov lower") // lower on
        step(56);
        `CHECK_EQ(lower_gate_drive, 2'b00, "discharge end") // low fb
        step(XSHUT - 80);
        `CHECK_EQ(upper_gate_drive[1], 1'b1, "aux shut early") // wait
        step(40);
        `CHECK_EQ(upper_gate_drive, 2'b00, "aux not shut") // other off
        `CHECK_EQ(power_good_out, 1'b0, "ov latch") // still held
        clear_latch(1'b0);
    endtask

    // aux target plus margin lies above the fixed level, so only aov acts
    task automatic t_aov_aux();
        aux_level = volt_t'(`AOV_LEVEL);
        step(150);
        `CHECK_EQ(power_good_out, 1'b1, "aov at limit") // threshold
        aux_level = volt_t'(`AOV_LEVEL) + 10'h001;
        step(FILT - 2);
        `CHECK_EQ(power_good_out, 1'b1, "aov early") // delay holds
        step(6);
        `CHECK_EQ(power_good_out, 1'b0, "aov pg") // pg drops
        `CHECK_EQ(upper_gate_drive, 2'b01, "aov upper") // aux rail
        `CHECK_EQ(lower_gate_drive, 2'b10, "aov lower") // lower on
        step(XSHUT - 24);
        `CHECK_EQ(upper_gate_drive[0], 1'b1, "core shut early") // wait
        step(40);
        `CHECK_EQ(upper_gate_drive, 2'b00, "core not shut") // off
        `CHECK_EQ(lower_gate_drive, 2'b00, "aux discharge") // low fb
        clear_latch(1'b1);
    endtask

    task automatic t_uv_core();
        core_level = CORE_UV;
        step(150);
        `CHECK_EQ(power_good_out, 1'b1, "uv at limit") // threshold
        core_level = CORE_UV - 10'h001;
        step(FILT - 2);
        `CHECK_EQ(power_good_out, 1'b1, "uv early") // delay holds
        step(6);
        `CHECK_EQ(power_good_out, 1'b0, "uv pg") // pg drops
        `CHECK_EQ(upper_gate_drive, 2'b10, "uv upper") // core off
        `CHECK_EQ(lower_gate_drive, 2'b00, "uv lower") // core off
        clear_latch(1'b0);
    endtask

    // uv limit of code 4 sits exactly on the level, code 3 one step above
    task automatic t_decode();
        core_voltage_code = 8'h04;
        step(150);
        `CHECK_EQ(power_good_out, 1'b1, "code 4 uv") // one step
        core_voltage_code = 8'h03;
        step(FILT + 4);
        `CHECK_EQ(upper_gate_drive, 2'b10, "code 3 uv") // one step
        clear_latch(1'b1);
    endtask

    task automatic t_code_off();
        core_voltage_code = `OFF_CODE;
        step(FILT + 10);
        `CHECK_EQ(power_good_out, 1'b0, "off code pg") // rail off
        `CHECK_EQ(upper_gate_drive, 2'b10, "off code upper") // off
        `CHECK_EQ(lower_gate_drive, 2'b00, "off code lower") // no ov
        clear_latch(1'b0);
    endtask

    task automatic t_thermal();
        over_temp_pin = 1'b1;
        step(5);
        `CHECK_EQ(upper_gate_drive, 2'b00, "ot upper") // all off
        `CHECK_EQ(lower_gate_drive, 2'b00, "ot lower") // all off
        `CHECK_EQ(power_good_out, 1'b0, "ot pg") // shut down
        over_temp_pin = 1'b0;
        step(20);
        `CHECK_EQ(upper_gate_drive, 2'b00, "ot latch") // held
        clear_latch(1'b1);
    endtask

    // ==========================================
    // clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // the whole run needs about 3600 cycles; over five times that is a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        enable_pin = 1'b1;
        supply_ok_pin = 1'b1;
        over_temp_pin = 1'b0;
        core_level = '0;
        aux_level = '0;
        core_cur_sense = '0;
        aux_cur_sense = '0;
        core_voltage_code = 8'h40;
        step(3);
        `CHECK_EQ(upper_gate_drive, 2'b00, "reset upper") // reset state
        `CHECK_EQ(power_good_out, 1'b0, "reset pg") // reset state
        `CHECK_EQ(core_volt_telem, 10'h000, "reset telem") // reset state
        rst = 1'b0;
        t_unarmed();
        t_telemetry();
        t_ov_core();
        t_aov_aux();
        t_uv_core();
        t_decode();
        t_code_off();
        t_thermal();
        end_of_test();
    end
endmodule
`default_nettype wire
